// File: logic/hbd_pkg.sv
// package: constants, types and register map for the bridge decode block
package hbd_pkg;

  // ----------------------------------------------------------------
  // operating modes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_DIR_EN = 2'h0;
  localparam logic [1:0] MODE_RSVD_A = 2'h1;
  localparam logic [1:0] MODE_RSVD_B = 2'h2;
  localparam logic [1:0] MODE_PWM = 2'h3;

  // ----------------------------------------------------------------
  // register map (byte addresses, word index = addr[3:2])
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_SETUP_C = 4'h0;
  localparam logic [3:0] ADDR_SETUP_B = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_VARIANT = 4'hC;

  // setup_reg_c fields
  localparam int SETUP_C_MODE_LSB = 0;
  localparam logic [1:0] SETUP_C_MODE_RST = 2'h0;
  // setup_reg_b fields
  localparam int SETUP_B_EXT_BIT = 0;
  localparam int SETUP_B_TRIP_EN_BIT = 1;
  localparam logic SETUP_B_EXT_RST = 1'b0;
  localparam logic SETUP_B_TRIP_EN_RST = 1'b0;
  // variant register fields
  localparam int VAR_SERIAL_BIT = 0;
  localparam int VAR_EXT_SUPPLY_BIT = 1;
  localparam logic VAR_SERIAL_RST = 1'b0;
  localparam logic VAR_EXT_SUPPLY_RST = 1'b0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int DEAD_TIME_NS = 8;
  localparam int DEAD_CYC = (DEAD_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int TRIP_OFF_US = 30;
  localparam int TRIP_OFF_CYC = TRIP_OFF_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HB_HIZ,
    HB_LOW,
    HB_HIGH
  } hbd_leg_t;

  typedef struct packed {
    hbd_leg_t leg_a;
    hbd_leg_t leg_b;
  } hbd_bridge_t;

  typedef struct packed {
    logic hi_on;
    logic lo_on;
  } hbd_gate_t;

  typedef struct packed {
    logic path_a;
    logic path_b;
  } hbd_sense_t;

  typedef enum logic [1:0] {
    DEV_SLEEP,
    DEV_STANDBY,
    DEV_ACTIVE
  } hbd_state_t;

endpackage

// File: logic/hbd_bridge_decode.sv
// bridge mode decode, dead time, trip forcing and sense path select
//
// The Avalon-MM slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module hbd_bridge_decode
  import hbd_pkg::*;
#(
  parameter int TRIP_OFF_CYCLES = TRIP_OFF_CYC,
  parameter int DEAD_CYCLES = DEAD_CYC
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  // pins (asynchronous, pull values applied outside as undriven levels)
  input wire logic sleep_n_input_i,
  input wire logic driver_off_input_i,
  input wire logic enable_or_input_a_i,
  input wire logic phase_or_input_b_i,
  input wire logic [1:0] mode_pin_i,
  input wire logic supply_por_ok_i,
  input wire logic trip_level_i,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // bridge
  output hbd_gate_t bridge_output_a_o,
  output hbd_gate_t bridge_output_b_o,
  output hbd_sense_t current_sense_output_o,
  output hbd_state_t dev_state_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // pin vector: por, mode[1:0], input b, input a, driver off, sleep
  logic [6:0] pins_raw;
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  assign pins_raw = {supply_por_ok_i, mode_pin_i, phase_or_input_b_i, enable_or_input_a_i,
                     driver_off_input_i, sleep_n_input_i};

  // first stage; reset holds the undriven levels: sleep low, off high
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sync1_q <= 7'h02;
    end else begin
      sync1_q <= pins_raw;
    end
  end

  // second stage; only this stage is read by logic
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sync2_q <= 7'h02;
    end else begin
      sync2_q <= sync1_q;
    end
  end

  wire logic sleep_n_s = sync2_q[0];
  wire logic drv_off_s = sync2_q[1];
  wire logic in_a_s = sync2_q[2];
  wire logic in_b_s = sync2_q[3];
  wire logic [1:0] mode_pin_s = sync2_q[5:4];
  wire logic por_ok_s = sync2_q[6];

  // trip comparator synchroniser
  logic trip_q1;
  logic trip_q2;
  logic trip_s;
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      trip_q1 <= 1'b0;
    end else begin
      trip_q1 <= trip_level_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      trip_q2 <= 1'b0;
    end else begin
      trip_q2 <= trip_q1;
    end
  end
  assign trip_s = trip_q2;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [1:0] mode_reg_q;
  logic ext_q;
  logic trip_en_q;
  logic serial_q;
  logic ext_supply_q;
  logic [1:0] mode_latch_q;
  logic sleep_n_eff;
  logic sleep_n_prev_q;
  logic [1:0] init_cnt_q;
  logic [1:0] mode_eff;
  logic rd_ack_q;
  hbd_bridge_t cmd_d;
  hbd_bridge_t cmd_q;
  hbd_bridge_t prev_q;
  hbd_state_t state_d;

  wire logic wr = avs_write & ~avs_read;

  // operating mode for the serial variant, applied as soon as it is written
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      mode_reg_q <= SETUP_C_MODE_RST;
    end else if (wr && avs_address == ADDR_SETUP_C) begin
      mode_reg_q <= avs_writedata[SETUP_C_MODE_LSB +: 2];
    end
  end

  // coast extend and trip enable
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      ext_q <= SETUP_B_EXT_RST;
      trip_en_q <= SETUP_B_TRIP_EN_RST;
    end else if (wr && avs_address == ADDR_SETUP_B) begin
      ext_q <= avs_writedata[SETUP_B_EXT_BIT];
      trip_en_q <= avs_writedata[SETUP_B_TRIP_EN_BIT];
    end
  end

  // variant straps
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      serial_q <= VAR_SERIAL_RST;
      ext_supply_q <= VAR_EXT_SUPPLY_RST;
    end else if (wr && avs_address == ADDR_VARIANT) begin
      serial_q <= avs_writedata[VAR_SERIAL_BIT];
      ext_supply_q <= avs_writedata[VAR_EXT_SUPPLY_BIT];
    end
  end

  // one wait state per read, so read data stands when waitrequest drops
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rd_ack_q <= 1'b0;
    end else begin
      rd_ack_q <= avs_read & ~rd_ack_q;
    end
  end
  assign avs_waitrequest = avs_read & ~rd_ack_q;

  // read data: setup and variant registers; status holds state, legs, effective mode
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !rd_ack_q) begin
      case (avs_address)
        ADDR_SETUP_C: avs_readdata <= {30'h0, mode_reg_q};
        ADDR_SETUP_B: avs_readdata <= {30'h0, trip_en_q, ext_q};
        ADDR_STATUS: avs_readdata <= {24'h0, state_d, cmd_q.leg_b, cmd_q.leg_a, mode_eff};
        ADDR_VARIANT: avs_readdata <= {30'h0, ext_supply_q, serial_q};
        default: avs_readdata <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // mode capture
  // ----------------------------------------------------------------
  assign sleep_n_eff = ext_supply_q ? por_ok_s : (sleep_n_s & por_ok_s);
  // wake edge detector; init waits until the synchroniser holds the pin
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sleep_n_prev_q <= 1'b0;
      init_cnt_q <= 2'h3;
      mode_latch_q <= MODE_DIR_EN;
    end else begin
      sleep_n_prev_q <= sleep_n_eff;
      if (init_cnt_q != 2'h0) begin
        init_cnt_q <= init_cnt_q - 2'h1;
      end
      if (init_cnt_q == 2'h1 || (sleep_n_eff && !sleep_n_prev_q)) begin
        mode_latch_q <= mode_pin_s;
      end
    end
  end
  // serial variant uses the register, hardwired the latched pin
  assign mode_eff = serial_q ? mode_reg_q : mode_latch_q;

  // ----------------------------------------------------------------
  // truth table decode
  // ----------------------------------------------------------------
  always_comb begin
    cmd_d = '{leg_a: HB_HIZ, leg_b: HB_HIZ};
    state_d = DEV_STANDBY;
    if (!sleep_n_eff) begin
      state_d = DEV_SLEEP;
    end else if (drv_off_s) begin
      state_d = DEV_STANDBY;
    end else begin
      case (mode_eff)
        MODE_DIR_EN: begin
          state_d = DEV_ACTIVE;
          if (!in_a_s) begin
            cmd_d = '{leg_a: HB_HIGH, leg_b: HB_HIGH};
          end else if (!in_b_s) begin
            cmd_d = '{leg_a: HB_LOW, leg_b: HB_HIGH};
          end else begin
            cmd_d = '{leg_a: HB_HIGH, leg_b: HB_LOW};
          end
        end
        MODE_PWM: begin
          state_d = DEV_ACTIVE;
          case ({in_a_s, in_b_s})
            2'h0: cmd_d = '{leg_a: HB_HIGH, leg_b: HB_HIGH};
            2'h1: cmd_d = '{leg_a: HB_LOW, leg_b: HB_HIGH};
            2'h2: cmd_d = '{leg_a: HB_HIGH, leg_b: HB_LOW};
            default: begin
              state_d = DEV_STANDBY;
              // coast: both legs float; with serial_q and ext_q set, only the switching leg floats after a forward or reverse drive
              if (serial_q && ext_q) begin
                if (prev_q.leg_a == HB_LOW && prev_q.leg_b == HB_HIGH) begin
                  cmd_d.leg_b = HB_HIGH;
                end else if (prev_q.leg_a == HB_HIGH && prev_q.leg_b == HB_LOW) begin
                  cmd_d.leg_a = HB_HIGH;
                end
              end
            end
          endcase
        end
        default: begin
          state_d = DEV_STANDBY;
        end
      endcase
    end
  end
  assign dev_state_o = state_d;

  // command register
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      cmd_q <= '{leg_a: HB_HIZ, leg_b: HB_HIZ};
    end else if (cmd_d != cmd_q) begin
      cmd_q <= cmd_d;
    end
  end

  // previous state held across coast so the extend choice stays stable
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      prev_q <= '{leg_a: HB_HIZ, leg_b: HB_HIZ};
    end else if (cmd_d != cmd_q) begin
      if (state_d != DEV_STANDBY || !(serial_q && ext_q)) begin
        prev_q <= cmd_d;
      end else if (cmd_d == '{leg_a: HB_HIZ, leg_b: HB_HIZ}) begin
        prev_q <= cmd_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // current trip forcing
  // ----------------------------------------------------------------
  // off-time counter, loaded by a trip while a low command holds, cleared by any new command
  logic [$clog2(TRIP_OFF_CYCLES+1)-1:0] trip_cnt_q;
  wire logic low_cmd = (cmd_q.leg_a == HB_LOW) ^ (cmd_q.leg_b == HB_LOW);
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      trip_cnt_q <= '0;
    end else if (cmd_d != cmd_q || !low_cmd) begin
      // a new command always wins over the forced recirculation
      trip_cnt_q <= '0;
    end else if (trip_cnt_q != '0) begin
      trip_cnt_q <= trip_cnt_q - 1'b1;
    end else if (trip_en_q && trip_s) begin
      trip_cnt_q <= ($clog2(TRIP_OFF_CYCLES+1))'(TRIP_OFF_CYCLES);
    end
  end

  hbd_bridge_t drive;
  // recirculate through the high side while the trip timer runs
  always_comb begin
    drive = cmd_q;
    if (trip_cnt_q != '0) begin
      if (drive.leg_a == HB_LOW) begin
        drive.leg_a = HB_HIGH;
      end
      if (drive.leg_b == HB_LOW) begin
        drive.leg_b = HB_HIGH;
      end
    end
  end

  // ----------------------------------------------------------------
  // dead time per leg
  // ----------------------------------------------------------------
  function automatic hbd_gate_t leg_gate(input hbd_leg_t leg);
    leg_gate = '{hi_on: leg == HB_HIGH, lo_on: leg == HB_LOW};
  endfunction
  hbd_gate_t gate_q [2];
  logic [$clog2(DEAD_CYCLES+1)-1:0] dead_q [2];
  for (genvar g = 0; g < 2; g++) begin : g_leg
    wire hbd_gate_t want = leg_gate(g == 0 ? drive.leg_a : drive.leg_b);
    always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
        gate_q[g] <= '0;
        dead_q[g] <= '0;
      end else if (want == gate_q[g]) begin
        dead_q[g] <= '0;
      end else if (gate_q[g] != '0) begin
        // break before make: both switches off first
        gate_q[g] <= '0;
        dead_q[g] <= ($clog2(DEAD_CYCLES+1))'(DEAD_CYCLES);
      end else if (dead_q[g] > 1) begin
        dead_q[g] <= dead_q[g] - 1'b1;
      end else begin
        gate_q[g] <= want;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign bridge_output_a_o = gate_q[0];
  assign bridge_output_b_o = gate_q[1];
  assign current_sense_output_o = '{path_a: gate_q[0].hi_on, path_b: gate_q[1].hi_on};

endmodule // hbd_bridge_decode

// File: test/hbd_bridge_decode_assertions.sv
// checker: port-level assertions for the bridge decode block
`timescale 1ns/100ps
module hbd_checker
  import hbd_pkg::*;
#(
  parameter int TRIP_OFF_CYCLES = 8,
  parameter int DEAD_CYCLES = 2
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic sleep_n_input_i,
  input wire logic driver_off_input_i,
  input wire logic enable_or_input_a_i,
  input wire logic phase_or_input_b_i,
  input wire logic supply_por_ok_i,
  input wire hbd_gate_t bridge_output_a_o,
  input wire hbd_gate_t bridge_output_b_o,
  input wire hbd_sense_t current_sense_output_o,
  input wire hbd_state_t dev_state_o
);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  logic brake_in;
  assign brake_in = sleep_n_input_i && !driver_off_input_i && supply_por_ok_i
    && !enable_or_input_a_i && !phase_or_input_b_i;
  a_no_shoot_a:
    assert property (!(bridge_output_a_o.hi_on && bridge_output_a_o.lo_on)) else $error("leg a");
  a_no_shoot_b:
    assert property (!(bridge_output_b_o.hi_on && bridge_output_b_o.lo_on)) else $error("leg b");
  a_gap_leg_a:
    assert property ($rose(bridge_output_a_o.lo_on) |-> !$past(bridge_output_a_o.hi_on))
    else $error("no gap on leg a");
  a_sleep_hiz:
    assert property (!sleep_n_input_i [*8] |-> bridge_output_a_o == 2'h0 && bridge_output_b_o == 2'h0)
    else $error("drive in sleep");
  a_sleep_state:
    assert property (!sleep_n_input_i [*4] |-> dev_state_o == DEV_SLEEP) else $error("not sleep");
  a_off_hiz:
    assert property (driver_off_input_i [*8] |-> bridge_output_a_o == 2'h0 && bridge_output_b_o == 2'h0)
    else $error("drive while off");
  a_brake_high:
    assert property (brake_in [*8] ##1 brake_in [*4] |-> bridge_output_a_o == 2'h2
      && bridge_output_b_o == 2'h2) else $error("no brake");
  a_sense_path:
    assert property (current_sense_output_o == {bridge_output_a_o.hi_on, bridge_output_b_o.hi_on})
    else $error("sense path");
  c_brake: cover property (brake_in [*8]);
  c_sleep: cover property (dev_state_o == DEV_SLEEP);
  c_coast: cover property (bridge_output_a_o == 2'h2 && bridge_output_b_o == 2'h0);
endmodule // hbd_checker

bind hbd_bridge_decode hbd_checker #(.TRIP_OFF_CYCLES(TRIP_OFF_CYCLES),
  .DEAD_CYCLES(DEAD_CYCLES)) hbd_checker_i (.core_clk_i, .reset_i, .sleep_n_input_i,
  .driver_off_input_i, .enable_or_input_a_i, .phase_or_input_b_i, .supply_por_ok_i,
  .bridge_output_a_o, .bridge_output_b_o, .current_sense_output_o, .dev_state_o);

// File: test/hbd_ctrl_model.sv
// controller model: drives the bridge pins of the decode block
`timescale 1ns/100ps
module hbd_ctrl_model (
  input wire logic core_clk_i,
  output logic sleep_n_o,
  output logic drv_off_o,
  output logic in_a_o,
  output logic in_b_o,
  output logic [1:0] mode_o,
  output logic por_ok_o,
  output logic trip_o
);
  // ----------------------------------------------------------------
  // undriven levels, then pin changes after an edge
  // ----------------------------------------------------------------
  initial begin
    {sleep_n_o, drv_off_o, in_a_o, in_b_o} = 4'h4;
    mode_o = 2'h0;
    por_ok_o = 1'b1;
    trip_o = 1'b0;
  end
  task automatic set_pins(input logic [3:0] v);
    @(posedge core_clk_i);
    {sleep_n_o, drv_off_o, in_a_o, in_b_o} <= v;
  endtask
  task automatic set_aux(input logic [1:0] m, input logic t);
    @(posedge core_clk_i);
    mode_o <= m;
    trip_o <= t;
  endtask
endmodule // hbd_ctrl_model

// File: test/tb_top.sv
// testbench: pin and register scenarios for the bridge decode block
`timescale 1ns/100ps
module tb_top;
  import hbd_pkg::*;
  localparam hbd_gate_t GH = 2'h2;
  localparam hbd_gate_t GL = 2'h1;
  localparam hbd_gate_t GZ = 2'h0;
  logic core_clk_i, reset_i, avs_read, avs_write, avs_waitrequest, sl, off, ia, ib, por, trip;
  logic [1:0] mpin;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  hbd_gate_t ga, gb;
  hbd_sense_t sns;
  hbd_state_t st;
  int num_errors = 0;
  int cmp_count = 0;
  hbd_ctrl_model hbd_ctrl_model_i (.core_clk_i(core_clk_i), .sleep_n_o(sl), .drv_off_o(off),
    .in_a_o(ia), .in_b_o(ib), .mode_o(mpin), .por_ok_o(por), .trip_o(trip));
  hbd_bridge_decode #(.TRIP_OFF_CYCLES(8), .DEAD_CYCLES(2)) hbd_bridge_decode_i (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .sleep_n_input_i(sl), .driver_off_input_i(off),
    .enable_or_input_a_i(ia), .phase_or_input_b_i(ib), .mode_pin_i(mpin),
    .supply_por_ok_i(por), .trip_level_i(trip), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .bridge_output_a_o(ga), .bridge_output_b_o(gb),
    .current_sense_output_o(sns), .dev_state_o(st));
  // ----------------------------------------------------------------
  // clock, tasks and scenarios
  // ----------------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge core_clk_i);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk_i);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic pins_chk(input logic [3:0] v, input hbd_gate_t ea, input hbd_gate_t eb,
      input hbd_state_t es);
    hbd_ctrl_model_i.set_pins(v);
    repeat (12) @(posedge core_clk_i);
    chk("leg a", {30'h0, ea}, {30'h0, ga});
    chk("leg b", {30'h0, eb}, {30'h0, gb});
    chk("sense", {30'h0, ea.hi_on, eb.hi_on}, {30'h0, sns});
    chk("state", {30'h0, es}, {30'h0, st});
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #40000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    {reset_i, avs_read, avs_write, avs_address, avs_writedata} = {3'h4, 4'h0, 32'h0};
    repeat (12) @(posedge core_clk_i);
    reset_i <= 1'b0;
    bus(1'b0, ADDR_SETUP_C, 32'h0);
    chk("mode reset", {30'h0, SETUP_C_MODE_RST}, rd);
    bus(1'b0, ADDR_VARIANT, 32'h0);
    chk("variant reset", {30'h0, VAR_EXT_SUPPLY_RST, VAR_SERIAL_RST}, rd);
    pins_chk(4'h8, GH, GH, DEV_ACTIVE);
    pins_chk(4'h9, GH, GH, DEV_ACTIVE);
    pins_chk(4'hA, GL, GH, DEV_ACTIVE);
    pins_chk(4'hB, GH, GL, DEV_ACTIVE);
    hbd_ctrl_model_i.set_aux(MODE_PWM, 1'b0);
    pins_chk(4'hB, GH, GL, DEV_ACTIVE);
    pins_chk(4'h3, GZ, GZ, DEV_SLEEP);
    pins_chk(4'hB, GZ, GZ, DEV_STANDBY);
    pins_chk(4'h8, GH, GH, DEV_ACTIVE);
    pins_chk(4'h9, GL, GH, DEV_ACTIVE);
    pins_chk(4'hA, GH, GL, DEV_ACTIVE);
    pins_chk(4'hE, GZ, GZ, DEV_STANDBY);
    bus(1'b1, ADDR_VARIANT, 32'h1);
    pins_chk(4'hB, GH, GL, DEV_ACTIVE);
    bus(1'b1, ADDR_SETUP_C, {30'h0, MODE_PWM});
    pins_chk(4'hB, GZ, GZ, DEV_STANDBY);
    bus(1'b0, ADDR_SETUP_C, 32'h0);
    chk("mode readback", {30'h0, MODE_PWM}, rd);
    bus(1'b1, ADDR_SETUP_C, {30'h0, MODE_RSVD_A});
    pins_chk(4'hA, GZ, GZ, DEV_STANDBY);
    bus(1'b1, ADDR_SETUP_C, {30'h0, MODE_RSVD_B});
    pins_chk(4'h9, GZ, GZ, DEV_STANDBY);
    bus(1'b1, ADDR_SETUP_C, {30'h0, MODE_PWM});
    bus(1'b1, ADDR_SETUP_B, 32'h1);
    pins_chk(4'hA, GH, GL, DEV_ACTIVE);
    pins_chk(4'hB, GH, GZ, DEV_STANDBY);
    pins_chk(4'h9, GL, GH, DEV_ACTIVE);
    pins_chk(4'hB, GZ, GH, DEV_STANDBY);
    pins_chk(4'h8, GH, GH, DEV_ACTIVE);
    pins_chk(4'hB, GZ, GZ, DEV_STANDBY);
    bus(1'b1, ADDR_SETUP_B, 32'h2);
    pins_chk(4'hA, GH, GL, DEV_ACTIVE);
    hbd_ctrl_model_i.set_aux(MODE_PWM, 1'b1);
    hbd_ctrl_model_i.set_aux(MODE_PWM, 1'b0);
    repeat (7) @(posedge core_clk_i);
    chk("trip leg b", {30'h0, GH}, {30'h0, gb});
    repeat (20) @(posedge core_clk_i);
    chk("trip end", {30'h0, GL}, {30'h0, gb});
    bus(1'b0, 4'h1, 32'h0);
    chk("unmapped", 32'h0, rd);
    report_and_stop();
  end
endmodule // tb_top
